/* logic/dbc_regs.vh */
// Constants for the contact input conditioning block: register offsets,
// field positions, reset values, setting limits and timing figures.
// Assumes a byte-addressed register port with one 32-bit word per register.
`ifndef DBC_REGS_VH
`define DBC_REGS_VH

// ------------------------------------------------------------------
// Sizes
// ------------------------------------------------------------------
`define DBC_NUM_IN      18
`define DBC_NUM_SIG     8

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define DBC_CLK_HZ      20000000
`define DBC_TICK_MS     1
`define DBC_MS_PER_S    10'd1000

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define DBC_OFS_FILT1   8'h00
`define DBC_OFS_FILT2   8'h04
`define DBC_OFS_SEL     8'h08
`define DBC_OFS_DIS     8'h0c
`define DBC_OFS_ENA     8'h10
`define DBC_OFS_AUTO    8'h14
`define DBC_OFS_ENACMD  8'h18
`define DBC_OFS_STATE   8'h1c
`define DBC_OFS_DISST   8'h20
`define DBC_OFS_IRQST   8'h24
`define DBC_OFS_IRQMSK  8'h28
`define DBC_OFS_ELEM    8'h2c
`define DBC_MAP_BASE    8'h40
`define DBC_MAP_MASK    8'he0

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define DBC_PER_MSB     3
`define DBC_PER_LSB     0
`define DBC_CNT_MSB     11
`define DBC_CNT_LSB     8
`define DBC_CHG_MSB     5
`define DBC_CHG_LSB     0
`define DBC_WIN_MSB     12
`define DBC_WIN_LSB     8
`define DBC_INS_MSB     7
`define DBC_INS_LSB     0
`define DBC_CEN_MSB     15
`define DBC_CEN_LSB     8
`define DBC_MAP_IDX_MSB 4
`define DBC_MAP_IDX_LSB 0
`define DBC_MAP_VALID   7

// ------------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------------
`define DBC_PER_DEF     6'h06
`define DBC_PER_MIN     6'h02
`define DBC_PER_MAX     6'h0a
`define DBC_CNT_DEF     6'h02
`define DBC_CNT_MIN     6'h01
`define DBC_CNT_MAX     6'h0a
`define DBC_CHG_DEF     6'h05
`define DBC_CHG_MIN     6'h02
`define DBC_CHG_MAX     6'h3c
`define DBC_WIN_DEF     6'h02
`define DBC_WIN_MIN     6'h01
`define DBC_WIN_MAX     6'h1e
`define DBC_SEL_DEF     18'h00000
`define DBC_AUTO_DEF    18'h3ffff
`define DBC_INS_DEF     8'h00
`define DBC_CEN_DEF     8'hff
`define DBC_MAP_DEF     6'h00

`endif

/* logic/dbc_channel.v */
// One contact input channel: sampling filter with consecutive-sample
// validation, then a chatter supervisor that freezes the output.
// Assumes the raw input is already synchronised and settings are legal.
`timescale 1ns/1ns
`default_nettype none

module dbc_channel
(
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  // Raw level and sample ticks
  input  wire       raw,
  input  wire       tick_f1,
  input  wire       tick_f2,
  input  wire       sec_tick,
  // Settings
  input  wire       filt_sel,
  input  wire [3:0] need1,
  input  wire [3:0] need2,
  input  wire [5:0] dis_thr,
  input  wire [4:0] dis_win,
  input  wire [5:0] ena_thr,
  input  wire [4:0] ena_win,
  input  wire       auto_dis,
  input  wire       ena_cmd,
  // Results
  output reg        out,
  output reg        disabled,
  output reg        dis_event
);

  reg        filt;
  reg  [3:0] same_cnt;
  reg  [5:0] chg;
  reg  [4:0] win;

  // Filter selection: the assigned filter supplies both tick and count.
  wire       tick  = filt_sel ? tick_f2 : tick_f1;
  wire [3:0] need  = filt_sel ? need2 : need1;
  wire       flip  = tick && (raw != filt) && ({1'b0, same_cnt} + 5'h01 >= {1'b0, need});
  wire       next_filt = flip ? raw : filt;

  // Window length follows the current mode of the supervisor.
  wire [4:0] win_len = disabled ? ena_win : dis_win;
  wire       win_end = sec_tick && ({1'b0, win} + 6'h01 >= {1'b0, win_len});
  wire [5:0] chg_inc = (flip && chg != 6'h3f) ? chg + 6'h01 : chg;

  wire trip   = !disabled && auto_dis && flip && (chg_inc > dis_thr);
  wire revive = disabled && (ena_cmd || (win_end && chg_inc < ena_thr));
  wire next_disabled = trip ? 1'b1 : (revive ? 1'b0 : disabled);

  // Filter: count samples that disagree with the output, clear on agreement.
  always @(posedge clk)
  begin
    if (reset)
    begin
      filt     <= 1'b0;
      same_cnt <= 4'h0;
    end
    else if (tick)
    begin
      if (raw != filt && !flip)
        same_cnt <= same_cnt + 4'h1;
      else
        same_cnt <= 4'h0;
      filt <= next_filt;
    end
  end

  // Chatter supervisor: fixed windows, restarted on every mode change.
  always @(posedge clk)
  begin
    if (reset)
    begin
      chg       <= 6'h00;
      win       <= 5'h00;
      disabled  <= 1'b0;
      out       <= 1'b0;
      dis_event <= 1'b0;
    end
    else
    begin
      disabled  <= next_disabled;
      out       <= next_disabled ? out : next_filt;
      dis_event <= trip;
      if (trip || revive || win_end)
      begin
        chg <= 6'h00;
        win <= 5'h00;
      end
      else
      begin
        chg <= chg_inc;
        win <= sec_tick ? win + 5'h01 : win;
      end
    end
  end

endmodule

`default_nettype wire

/* logic/dbc_input_block.v */
// Contact input conditioning block: two sampling filters, chatter
// supervision, logic signal mapping and protection element enables.
// Assumes a 20 MHz clock, a simple register port and asynchronous pins.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "dbc_regs.vh"

// Behaviour
// - Filter one samples every 2-10 ms
// - Filter two has own 2-10 ms period
// - Output changes after N equal consecutive samples
// - Filter one count 1-10, default 2
// - Filter two count 1-10, default 2
// - Per input filter select, default filter one
// - Too many changes disable, hold last state
// - Disable threshold 2-60, window 1-30 s
// - Re-enable by window criteria or command
// - Re-enable threshold 2-60, window 1-30 s
// - Automatic disable per input, default yes
// - Element enable defaults to one
// - Enable from panel, input or command; here panel, mapped input and command bits must all allow it
// - Out of service element drives nothing
// - Each logic signal has one source
module dbc_input_block
#(
  parameter MS_CYCLES = `DBC_CLK_HZ / 1000 * `DBC_TICK_MS
)
(
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // Contact pins and conditioned levels
  input  wire [17:0] contact_input_line,
  output wire [17:0] status_input_line,
  // Logic signals mapped from the contact inputs
  output reg  [7:0]  logic_signal,
  // Protection elements
  input  wire [7:0]  panel_disable,
  input  wire [7:0]  elem_raw_signal,
  output reg  [7:0]  elem_in_service,
  output reg  [7:0]  elem_signal,
  // Interrupt
  output wire        irq
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------

  // Settings are clamped so a bad write cannot stall a filter or window.
  function [5:0] clamp;
    input [5:0] v;
    input [5:0] lo;
    input [5:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // Sample periods only come in even milliseconds.
  function [3:0] period_of;
    input [31:0] w;
    reg   [5:0]  c;
    begin
      c = clamp({2'b00, w[`DBC_PER_MSB:`DBC_PER_LSB]}, `DBC_PER_MIN, `DBC_PER_MAX);
      period_of = {c[3:1], 1'b0};
    end
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  reg [17:0] in_meta;
  reg [17:0] in_sync;
  reg [7:0]  pan_meta;
  reg [7:0]  pan_sync;

  // Two stages each; only the second stage is read by any logic.
  always @(posedge clk)
  begin
    if (reset)
    begin
      in_meta  <= 18'h00000;
      in_sync  <= 18'h00000;
      pan_meta <= 8'h00;
      pan_sync <= 8'h00;
    end
    else
    begin
      in_meta  <= contact_input_line;
      in_sync  <= in_meta;
      pan_meta <= panel_disable;
      pan_sync <= pan_meta;
    end
  end

  // ------------------------------------------------------------------
  // Settings registers
  // ------------------------------------------------------------------
  reg [31:0] filt1_reg;
  reg [31:0] filt2_reg;
  reg [17:0] sel_reg;
  reg [31:0] dis_reg;
  reg [31:0] ena_reg;
  reg [17:0] auto_reg;
  reg [17:0] ena_cmd;
  reg [17:0] irq_status;
  reg [17:0] irq_mask;
  reg [7:0]  ins_reg;
  reg [7:0]  cen_reg;
  reg [5:0]  map_ent [0:7];
  wire [17:0] disabled;
  wire [17:0] dis_event;
  integer    k;
  integer    j;

  // Reset defaults held as sized values, so that their fields can be sliced.
  localparam [5:0]  CNT_DEF = `DBC_CNT_DEF;
  localparam [5:0]  PER_DEF = `DBC_PER_DEF;
  localparam [5:0]  WIN_DEF = `DBC_WIN_DEF;
  localparam [31:0] MS_LAST = MS_CYCLES - 1;

  wire map_hit = (addr & `DBC_MAP_MASK) == `DBC_MAP_BASE;
  wire [2:0] map_idx = addr[4:2];

  // Register writes; the enable command is a one-cycle pulse per input.
  always @(posedge clk)
  begin
    if (reset)
    begin
      filt1_reg <= {20'h00000, CNT_DEF[3:0], 4'h0, PER_DEF[3:0]};
      filt2_reg <= {20'h00000, CNT_DEF[3:0], 4'h0, PER_DEF[3:0]};
      sel_reg   <= `DBC_SEL_DEF;
      dis_reg   <= {19'h00000, WIN_DEF[4:0], 2'b00, `DBC_CHG_DEF};
      ena_reg   <= {19'h00000, WIN_DEF[4:0], 2'b00, `DBC_CHG_DEF};
      auto_reg  <= `DBC_AUTO_DEF;
      ena_cmd   <= 18'h00000;
      irq_mask  <= 18'h00000;
      ins_reg   <= `DBC_INS_DEF;
      cen_reg   <= `DBC_CEN_DEF;
      for (j = 0; j < `DBC_NUM_SIG; j = j + 1)
        map_ent[j] <= `DBC_MAP_DEF;
    end
    else
    begin
      ena_cmd <= 18'h00000;
      if (wr)
      begin
        if (map_hit)
          map_ent[map_idx] <= {wdata[`DBC_MAP_VALID], wdata[`DBC_MAP_IDX_MSB:`DBC_MAP_IDX_LSB]};
        else
        begin
          case (addr)
            `DBC_OFS_FILT1:  filt1_reg <= wdata;
            `DBC_OFS_FILT2:  filt2_reg <= wdata;
            `DBC_OFS_SEL:    sel_reg   <= wdata[17:0];
            `DBC_OFS_DIS:    dis_reg   <= wdata;
            `DBC_OFS_ENA:    ena_reg   <= wdata;
            `DBC_OFS_AUTO:   auto_reg  <= wdata[17:0];
            `DBC_OFS_ENACMD: ena_cmd   <= wdata[17:0];
            `DBC_OFS_IRQMSK: irq_mask  <= wdata[17:0];
            `DBC_OFS_ELEM:
            begin
              ins_reg <= wdata[`DBC_INS_MSB:`DBC_INS_LSB];
              cen_reg <= wdata[`DBC_CEN_MSB:`DBC_CEN_LSB];
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Effective settings after clamping to their legal ranges.
  wire [3:0] per1  = period_of(filt1_reg);
  wire [3:0] per2  = period_of(filt2_reg);
  wire [5:0] need1 = clamp({2'b00, filt1_reg[`DBC_CNT_MSB:`DBC_CNT_LSB]}, `DBC_CNT_MIN,
                           `DBC_CNT_MAX);
  wire [5:0] need2 = clamp({2'b00, filt2_reg[`DBC_CNT_MSB:`DBC_CNT_LSB]}, `DBC_CNT_MIN,
                           `DBC_CNT_MAX);
  wire [5:0] dis_thr = clamp(dis_reg[`DBC_CHG_MSB:`DBC_CHG_LSB], `DBC_CHG_MIN, `DBC_CHG_MAX);
  wire [5:0] ena_thr = clamp(ena_reg[`DBC_CHG_MSB:`DBC_CHG_LSB], `DBC_CHG_MIN, `DBC_CHG_MAX);
  wire [5:0] dis_win = clamp({1'b0, dis_reg[`DBC_WIN_MSB:`DBC_WIN_LSB]}, `DBC_WIN_MIN,
                             `DBC_WIN_MAX);
  wire [5:0] ena_win = clamp({1'b0, ena_reg[`DBC_WIN_MSB:`DBC_WIN_LSB]}, `DBC_WIN_MIN,
                             `DBC_WIN_MAX);

  // ------------------------------------------------------------------
  // Timebase
  // ------------------------------------------------------------------
  reg [14:0] ms_cnt;
  reg [3:0]  f1_cnt;
  reg [3:0]  f2_cnt;
  reg [9:0]  s_cnt;
  reg        tick_f1;
  reg        tick_f2;
  reg        sec_tick;
  wire       ms_tick = (ms_cnt == MS_LAST[14:0]);

  always @(posedge clk)
  begin
    if (reset)
    begin
      ms_cnt   <= 15'h0000;
      f1_cnt   <= 4'h0;
      f2_cnt   <= 4'h0;
      s_cnt    <= 10'h000;
      tick_f1  <= 1'b0;
      tick_f2  <= 1'b0;
      sec_tick <= 1'b0;
    end
    else
    begin
      ms_cnt   <= ms_tick ? 15'h0000 : ms_cnt + 15'h0001;
      tick_f1  <= 1'b0;
      tick_f2  <= 1'b0;
      sec_tick <= 1'b0;
      if (ms_tick)
      begin
        if (f1_cnt + 4'h1 >= per1)
        begin
          f1_cnt  <= 4'h0;
          tick_f1 <= 1'b1;
        end
        else
          f1_cnt <= f1_cnt + 4'h1;
        if (f2_cnt + 4'h1 >= per2)
        begin
          f2_cnt  <= 4'h0;
          tick_f2 <= 1'b1;
        end
        else
          f2_cnt <= f2_cnt + 4'h1;
        if (s_cnt == `DBC_MS_PER_S - 10'd1)
        begin
          s_cnt    <= 10'h000;
          sec_tick <= 1'b1;
        end
        else
          s_cnt <= s_cnt + 10'h001;
      end
    end
  end

  // ------------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `DBC_NUM_IN; g = g + 1)
    begin : ch
      dbc_channel u_ch
      (
        .clk       (clk),
        .reset     (reset),
        .raw       (in_sync[g]),
        .tick_f1   (tick_f1),
        .tick_f2   (tick_f2),
        .sec_tick  (sec_tick),
        .filt_sel  (sel_reg[g]),
        .need1     (need1[3:0]),
        .need2     (need2[3:0]),
        .dis_thr   (dis_thr),
        .dis_win   (dis_win[4:0]),
        .ena_thr   (ena_thr),
        .ena_win   (ena_win[4:0]),
        .auto_dis  (auto_reg[g]),
        .ena_cmd   (ena_cmd[g]),
        .out       (status_input_line[g]),
        .disabled  (disabled[g]),
        .dis_event (dis_event[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Mapping and element enables
  // ------------------------------------------------------------------

  // A signal may share its contact with others but never has two sources.
  always @(posedge clk)
  begin
    if (reset)
    begin
      logic_signal    <= 8'h00;
      elem_in_service <= 8'h00;
      elem_signal     <= 8'h00;
    end
    else
    begin
      for (k = 0; k < `DBC_NUM_SIG; k = k + 1)
      begin
        logic_signal[k] <= map_ent[k][5] && (map_ent[k][4:0] < `DBC_NUM_IN) &&
                           status_input_line[map_ent[k][4:0]];
        elem_in_service[k] <= ins_reg[k] && cen_reg[k] && !pan_sync[k] &&
                              (!map_ent[k][5] || logic_signal[k]);
        elem_signal[k] <= elem_in_service[k] && elem_raw_signal[k];
      end
    end
  end

  // ------------------------------------------------------------------
  // Interrupt and read-back
  // ------------------------------------------------------------------
  wire st_read = rd && (addr == `DBC_OFS_IRQST);

  // A disable event in the clearing cycle survives the read.
  always @(posedge clk)
  begin
    if (reset)
      irq_status <= 18'h00000;
    else
      irq_status <= (st_read ? 18'h00000 : irq_status) | dis_event;
  end

  assign irq = |(irq_status & irq_mask);

  // Read data stand for exactly one cycle; unmapped addresses read zero.
  always @(posedge clk)
  begin
    if (reset)
      rdata <= 32'h00000000;
    else if (!rd)
      rdata <= 32'h00000000;
    else if (map_hit)
      rdata <= {24'h000000, map_ent[map_idx][5], 2'b00, map_ent[map_idx][4:0]};
    else
    begin
      case (addr)
        `DBC_OFS_FILT1:  rdata <= filt1_reg;
        `DBC_OFS_FILT2:  rdata <= filt2_reg;
        `DBC_OFS_SEL:    rdata <= {14'h0000, sel_reg};
        `DBC_OFS_DIS:    rdata <= dis_reg;
        `DBC_OFS_ENA:    rdata <= ena_reg;
        `DBC_OFS_AUTO:   rdata <= {14'h0000, auto_reg};
        `DBC_OFS_STATE:  rdata <= {14'h0000, status_input_line};
        `DBC_OFS_DISST:  rdata <= {14'h0000, disabled};
        `DBC_OFS_IRQST:  rdata <= {14'h0000, irq_status};
        `DBC_OFS_IRQMSK: rdata <= {14'h0000, irq_mask};
        `DBC_OFS_ELEM:   rdata <= {16'h0000, cen_reg, ins_reg};
        default:         rdata <= 32'h00000000;
      endcase
    end
  end

endmodule

`default_nettype wire

/* tb/dbc_contact_model.sv */
// Field contact model: pins follow the requested level after a bounce.
// Assumes the bench moves the level right after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none

module dbc_contact_model
#(
  parameter BOUNCE = 5
)
(
  // Clock
  input  wire logic        clk,
  // Requested contact level
  input  wire logic [17:0] level,
  // Contact pins
  output var  logic [17:0] pins
);
  logic [17:0] last   = 18'h0;
  logic [17:0] moving = 18'h0;
  int          cnt    = 0;

  initial pins = 18'h0;

  // A moving contact rattles, so changed bits flicker before settling.
  // The filter must not take the flicker as a valid change.
  always @(posedge clk)
  begin
    last <= level;
    if (level != last)
    begin
      moving <= level ^ last;
      cnt    <= BOUNCE;
      pins   <= level;
    end
    else if (cnt > 0)
    begin
      cnt  <= cnt - 1;
      pins <= pins ^ moving;
    end
    else
      pins <= level;
  end
endmodule

`default_nettype wire

/* tb/dbc_input_block_chk.sv */
// Port checker for the contact input block.
// Assumes only the top module's ports are visible; bound below.
`timescale 1ns/1ns
`default_nettype none

module dbc_input_block_chk
#(
  parameter MS_CYCLES = 20
)
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Contacts and logic signals
  input wire logic [17:0] contact_input_line,
  input wire logic [17:0] status_input_line,
  input wire logic [7:0]  logic_signal,
  // Elements and interrupt
  input wire logic [7:0]  panel_disable,
  input wire logic [7:0]  elem_raw_signal,
  input wire logic [7:0]  elem_in_service,
  input wire logic [7:0]  elem_signal,
  input wire logic        irq
);
  default clocking dbc_cb @(posedge clk);
  endclocking

  // ----------------------------
  // Sequences
  // ----------------------------
  sequence s_no_read;
    !rd;
  endsequence

  sequence s_state_move;
    $changed(status_input_line);
  endsequence

  // ----------------------------
  // Assertions
  // ----------------------------
  // read data idle
  chk_rdata_idle: assert property (disable iff (reset) s_no_read |=> rdata == 32'h0)
    else $error("read data not zero outside a read");

  // reset clears outputs; reset itself cannot disable this one.
  chk_reset_clear: assert property (reset |=> rdata == 32'h0 && status_input_line == 18'h0
    && logic_signal == 8'h00 && elem_in_service == 8'h00 && !irq)
    else $error("outputs not cleared by reset");

  chk_state_hold: assert property (disable iff (reset) s_state_move |=>
    $stable(status_input_line) [*8])
    else $error("filtered state moved between sample ticks");

  chk_elem_raw: assert property (disable iff (reset)
    (elem_signal & ~$past(elem_raw_signal)) == 8'h00)
    else $error("element signal without raw activity");

  chk_elem_svc: assert property (disable iff (reset)
    (elem_signal & ~(elem_in_service | $past(elem_in_service))) == 8'h00)
    else $error("element out of service drives a signal");

  chk_panel_out: assert property (disable iff (reset) (elem_in_service &
    $past(panel_disable, 2) & $past(panel_disable, 3) & $past(panel_disable, 4)) == 8'h00)
    else $error("element in service while panel holds it out");

  chk_irq_fall: assert property (disable iff (reset) $fell(irq) |-> $past(rd) || $past(wr))
    else $error("interrupt dropped without a register access");

  chk_logic_src: assert property (disable iff (reset) logic_signal != 8'h00 |->
    status_input_line != 18'h0 || $past(status_input_line) != 18'h0)
    else $error("logic signal set with no active contact");
endmodule

bind dbc_input_block dbc_input_block_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (
  .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .contact_input_line(contact_input_line),
  .status_input_line(status_input_line), .logic_signal(logic_signal),
  .panel_disable(panel_disable), .elem_raw_signal(elem_raw_signal),
  .elem_in_service(elem_in_service), .elem_signal(elem_signal), .irq(irq));

`default_nettype wire

/* tb/tb_dbc_input_block.sv */
// Directed bench for the contact input block over its register port.
// Assumes one millisecond is shortened to 20 clock cycles.
`timescale 1ns/1ns
`default_nettype none

module tb_dbc_input_block;
  localparam int MS = 20;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [17:0] level = 18'h0;
  logic [7:0]  panel_disable = 8'h00;
  logic [7:0]  elem_raw_signal = 8'h00;
  wire logic [31:0] rdata;
  wire logic [17:0] pins;
  wire logic [17:0] st;
  wire logic [7:0]  lsig;
  wire logic [7:0]  esvc;
  wire logic [7:0]  esig;
  wire logic        irq;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          chg2 = 0;
  int          chg3 = 0;
  int          c2;
  int          c3;
  int          t0;
  logic [17:0] prev_st = 18'h0;
  logic [7:0]  ra [14] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                           8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h40};
  logic [31:0] rv [14] = '{32'h206, 32'h206, 32'h0, 32'h205, 32'h205, 32'h3ffff,
                           32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hff00, 32'h0, 32'h0};

  dbc_contact_model i_contacts (.clk(clk), .level(level), .pins(pins));

  dbc_input_block #(.MS_CYCLES(MS)) i_dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .contact_input_line(pins), .status_input_line(st),
    .logic_signal(lsig), .panel_disable(panel_disable),
    .elem_raw_signal(elem_raw_signal), .elem_in_service(esvc),
    .elem_signal(esig), .irq(irq));

  // 50 ns period.
  always #25 clk = ~clk;

  // ----------------------------
  // Tasks
  // ----------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Strobes drop with a spare edge, so calls never collide in one step.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    tick(1);
    wr    <= 1'b0;
    tick(1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd   <= 1'b1;
    tick(1);
    rd   <= 1'b0;
    tick(1);
    check(rdata, exp);
  endtask

  task automatic toggle(input int n, input logic [17:0] m);
    repeat (n)
    begin
      level <= level ^ m;
      tick(100);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cycle count, change counters and the hang limit.
  always @(posedge clk)
  begin
    cyc     <= cyc + 1;
    prev_st <= st;
    if (st[2] !== prev_st[2])
      chg2 <= chg2 + 1;
    if (st[3] !== prev_st[3])
      chg3 <= chg3 + 1;
    if (cyc == 95000)
    begin
      n_fail = n_fail + 1;
      close_out();
    end
  end

  // ----------------------------
  // Tests
  // ----------------------------
  initial
  begin
    tick(2);
    reset <= 1'b0;
    tick(1);
    wr_reg(8'h1c, 32'h3ffff);
    wr_reg(8'h30, 32'hffff);
    for (int i = 0; i < 14; i++)
      rd_chk(ra[i], rv[i]);
    $display("test register defaults done");

    // Filter one 2 ms x3, filter two 10 ms x2 on input 1.
    wr_reg(8'h00, 32'h302);
    wr_reg(8'h04, 32'h20a);
    wr_reg(8'h08, 32'h2);
    tick(300);
    for (int v = 1; v >= 0; v--)
    begin
      level[1:0] <= {2{v[0]}};
      tick(75);
      check(st[0], !v[0]);
      tick(60);
      check(st[1:0], {!v[0], v[0]});
      tick(295);
      check(st[1:0], {2{v[0]}});
    end
    $display("test filters done");

    // Chatter on inputs 2 and 3; input 3 has automatic disable off.
    wr_reg(8'h00, 32'h102);
    wr_reg(8'h0c, 32'h102);
    wr_reg(8'h10, 32'h202);
    wr_reg(8'h14, 32'h3fff7);
    while (cyc % 20000 < 500 || cyc % 20000 > 17000)
      tick(1);
    c2 = chg2;
    c3 = chg3;
    toggle(5, 18'hc);
    check(chg2 - c2, 2);
    check(chg3 - c3, 5);
    check(st[2], 1'b0);
    rd_chk(8'h20, 32'h4);
    check(irq, 1'b0);
    wr_reg(8'h28, 32'h4);
    check(irq, 1'b1);
    rd_chk(8'h24, 32'h4);
    check(irq, 1'b0);
    rd_chk(8'h24, 32'h0);
    wr_reg(8'h18, 32'h4);
    tick(3);
    check(st[2], 1'b1);
    rd_chk(8'h20, 32'h0);
    toggle(3, 18'h4);
    check(st[2], 1'b1);
    check(irq, 1'b1);
    rd_chk(8'h24, 32'h4);
    t0 = cyc;
    for (int i = 0; i < 42000 && st[2] !== 1'b0; i++)
      tick(1);
    check(cyc - t0 >= 19000, 1'b1);
    check(st[2], 1'b0);
    rd_chk(8'h20, 32'h0);
    $display("test chatter done");

    // Logic 0 and 1 from input 3, logic 2 from input 2.
    wr_reg(8'h40, 32'h83);
    wr_reg(8'h44, 32'h83);
    wr_reg(8'h48, 32'h82);
    elem_raw_signal <= 8'hff;
    wr_reg(8'h2c, 32'hffff);
    tick(5);
    check(lsig, 8'h03);
    check(esvc, 8'hfb);
    check(esig, 8'hfb);
    panel_disable <= 8'h80;
    wr_reg(8'h2c, 32'hbfdf);
    tick(5);
    check(esvc, 8'h1b);
    elem_raw_signal <= 8'h0f;
    tick(3);
    check(esig, 8'h0b);
    $display("test elements done");

    reset <= 1'b1;
    tick(2);
    check(st, 18'h0);
    check(irq, 1'b0);
    reset <= 1'b0;
    tick(1);
    rd_chk(8'h0c, 32'h205);
    tick(300);
    check(st[3], 1'b1);
    $display("test second reset done");
    close_out();
  end
endmodule

`default_nettype wire
